// ==== fsr_pkg.sv ====
// Package of register map, field positions and timing for the shadow and ring config block
package fsr_pkg;
	localparam logic [11:0] FSR_OFF_DISK_CHANGE  = 12'h304;
	localparam logic [11:0] FSR_OFF_RATE_SHADOW  = 12'h308;
	localparam logic [11:0] FSR_OFF_SER1_SHADOW  = 12'h30C;
	localparam logic [11:0] FSR_OFF_SER2_SHADOW  = 12'h310;
	localparam logic [11:0] FSR_OFF_WRITE_PROT   = 12'h314;
	localparam logic [11:0] FSR_OFF_RING_FILTER  = 12'h318;
	localparam logic [11:0] FSR_OFF_IRQ_STATUS   = 12'h400;
	localparam logic [11:0] FSR_OFF_IRQ_MASK     = 12'h404;
	localparam logic [7:0]  FSR_IDX_RATE_SHADOW  = 8'hC2;
	localparam logic [7:0]  FSR_IDX_SER1_SHADOW  = 8'hC3;
	localparam logic [7:0]  FSR_IDX_SER2_SHADOW  = 8'hC4;
	localparam logic [7:0]  FSR_IDX_WRITE_PROT   = 8'hC5;
	localparam logic [7:0]  FSR_IDX_RING_FILTER  = 8'hC6;
	localparam logic [7:0]  FSR_RST_DISK_CHANGE  = 8'h03;
	localparam logic [7:0]  FSR_RST_WRITE_PROT   = 8'h00;
	localparam logic [7:0]  FSR_RST_RING_FILTER  = 8'h00;
	localparam logic [7:0]  FSR_RST_SHADOW       = 8'h00;
	localparam logic [7:0]  FSR_MASK_DISK_CHANGE = 8'h03;
	localparam logic [7:0]  FSR_MASK_WRITE_PROT  = 8'h01;
	localparam logic [7:0]  FSR_MASK_RING_FILTER = 8'hC7;
	localparam int          FSR_BIT_CRYSTAL_LOAD_SEL     = 6;
	localparam int          FSR_BIT_KBC_LINE     = 7;
	localparam int          FSR_CLK_HZ           = 25000000;
	localparam int          FSR_TRAIN_MS         = 200;
	localparam int          FSR_MIN_TRAIN_HZ     = 15;
	localparam int          FSR_TRAIN_CYC        = FSR_CLK_HZ / 1000 * FSR_TRAIN_MS;
	localparam int          FSR_GAP_CYC          = FSR_CLK_HZ / FSR_MIN_TRAIN_HZ;
	localparam int          FSR_CNT_W            = 24;
endpackage : fsr_pkg

// ==== fsr_ring_det.sv ====
// Ring detector: plain edge or pulse-train filter on one synchronised ring pin
`timescale 1ns/1ns
`default_nettype none
module fsr_ring_det
	import fsr_pkg::*;
#(
	parameter int TRAIN_CYC = FSR_TRAIN_CYC,
	parameter int GAP_CYC   = FSR_GAP_CYC
) (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic pin_n,
	input  wire logic filter_en,
	output logic      ring_pulse_n,
	output logic      ring_event
);
	logic                 meta;
	logic                 sync;
	logic                 prev;
	logic [FSR_CNT_W-1:0] gap_cnt;
	logic [FSR_CNT_W-1:0] train_cnt;
	logic                 train_on;
	wire  fall       = prev & ~sync;
	wire  gap_over   = gap_cnt >= FSR_CNT_W'(GAP_CYC);
	wire  train_done = train_cnt >= FSR_CNT_W'(TRAIN_CYC);
	wire  start      = filter_en & fall & ~train_on;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= pin_n;
			sync <= meta;
			prev <= sync;
		end
	end

	// Train runs while falling edges keep coming faster than the minimum rate, and ends once train_cnt reaches TRAIN_CYC
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_cnt   <= '0;
			train_cnt <= '0;
			train_on  <= 1'b0;
		end else begin
			gap_cnt <= fall ? '0 : (gap_over ? gap_cnt : gap_cnt + 1'b1);
			if (!filter_en || (train_on && (gap_over || train_done))) begin
				train_on  <= 1'b0;
				train_cnt <= '0;
			end else if (fall) begin
				train_on  <= 1'b1;
				train_cnt <= train_on ? train_cnt + 1'b1 : '0;
			end else if (train_on) begin
				train_cnt <= train_cnt + 1'b1;
			end
		end
	end

	// Leading falling edge of the filtered pulse, or the raw edge, signals ring
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ring_pulse_n <= 1'b1;
			ring_event   <= 1'b0;
		end else begin
			ring_pulse_n <= ~(train_on & ~gap_over & ~train_done) & ~start;
			ring_event   <= filter_en ? start : fall;
		end
	end
endmodule : fsr_ring_det
`default_nettype wire

// ==== fsr_cfg.sv ====
// Shadow, forced-input and ring filter configuration registers behind APB
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Bit0 forces drive zero disk change
// - Bit1 forces drive one disk change
// - Forcing only while that drive selected
// - Disk change bits 7:2 read zero
// - Index C2 mirrors floppy rate select
// - Index C3 mirrors first queue control
// - Index C4 mirrors second queue control
// - Force bit makes write protect asserted
// - Applies to floppy and parallel pins
// - Bit0 drive zero, default off, selected
// - Write protect bits 7:1 read zero
// - Bit0 filters wake ring pulse train
// - Bit1 filters port A ring
// - Bit2 filters port B ring
// - Bit6 selects crystal load capacitance
// - Bit7 selects keyboard port line
// - Step with select clears force bit
// - Disk changed status is OR combination
module fsr_cfg
	import fsr_pkg::*;
#(
	parameter int TRAIN_CYC = FSR_TRAIN_CYC,
	parameter int GAP_CYC   = FSR_GAP_CYC
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rate_wr,
	input  wire logic        ser1_queue_wr,
	input  wire logic        ser2_queue_wr,
	input  wire logic [7:0]  host_wdata,
	input  wire logic        disk_change_in_n,
	input  wire logic        write_protect_in_n,
	input  wire logic        pp_write_protect_in_n,
	input  wire logic        head_step_n,
	input  wire logic        drive_select_zero_n,
	input  wire logic        drive_select_one_n,
	input  wire logic        wake_ring_in_n,
	input  wire logic        ring_ind_port_a_n,
	input  wire logic        ring_ind_port_b_n,
	output logic             disk_changed_status,
	output logic             disk_change_seen_n,
	output logic             write_protect_seen_n,
	output logic             pp_write_protect_seen_n,
	output logic             wake_ring_out_n,
	output logic             ring_port_a_out_n,
	output logic             ring_port_b_out_n,
	output logic             crystal_load_sel,
	output logic             kbc_port_line_sel,
	output logic             irq
);
	logic [7:0] disk_change;
	logic [7:0] write_prot;
	logic [7:0] ring_filter;
	logic [7:0] rate_shadow;
	logic [7:0] ser1_shadow;
	logic [7:0] ser2_shadow;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [2:0] ring_ev;
	logic [2:0] ring_pn;

	// Floppy pins arrive asynchronously; two flops before any use
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta <= 6'h3F;
			pin_sync <= 6'h3F;
		end else begin
			pin_meta <= {pp_write_protect_in_n, disk_change_in_n, write_protect_in_n,
				head_step_n, drive_select_zero_n, drive_select_one_n};
			pin_sync <= pin_meta;
		end
	end
	wire pp_wp_n = pin_sync[5];
	wire dchg_n  = pin_sync[4];
	wire wp_n    = pin_sync[3];
	wire step    = ~pin_sync[2];
	wire sel0    = ~pin_sync[1];
	wire sel1    = ~pin_sync[0];

	wire access   = psel & penable;
	wire wr       = access & pwrite;
	wire hit_dc   = paddr == FSR_OFF_DISK_CHANGE;
	wire hit_rate = paddr == FSR_OFF_RATE_SHADOW;
	wire hit_s1   = paddr == FSR_OFF_SER1_SHADOW;
	wire hit_s2   = paddr == FSR_OFF_SER2_SHADOW;
	wire hit_wp   = paddr == FSR_OFF_WRITE_PROT;
	wire hit_rf   = paddr == FSR_OFF_RING_FILTER;
	wire hit_st   = paddr == FSR_OFF_IRQ_STATUS;
	wire hit_mk   = paddr == FSR_OFF_IRQ_MASK;
	wire mapped   = hit_dc | hit_rate | hit_s1 | hit_s2 | hit_wp | hit_rf | hit_st | hit_mk;
	wire ro_hit   = hit_rate | hit_s1 | hit_s2;
	wire bad      = ~mapped | (pwrite & ro_hit);
	wire [7:0] dc_set = (wr & hit_dc) ? (pwdata[7:0] & FSR_MASK_DISK_CHANGE) : 8'h00;
	wire [7:0] dc_clr = {6'h00, step & sel1, step & sel0};
	// Software may only set force bits; hardware clear, set wins on collision
	wire [7:0] next_disk_change = (disk_change & ~dc_clr) | dc_set;
	wire [2:0] next_irq_status = (irq_status & ~((wr & hit_st) ? pwdata[2:0] : 3'h0)) | ring_ev;

	wire [31:0] rd_mux =
		hit_dc   ? {24'h0, disk_change & FSR_MASK_DISK_CHANGE} :
		hit_rate ? {24'h0, rate_shadow} :
		hit_s1   ? {24'h0, ser1_shadow} :
		hit_s2   ? {24'h0, ser2_shadow} :
		hit_wp   ? {24'h0, write_prot & FSR_MASK_WRITE_PROT} :
		hit_rf   ? {24'h0, ring_filter} :
		hit_st   ? {29'h0, irq_status} :
		hit_mk   ? {29'h0, irq_mask} : 32'h0;

	wire force_dc0 = disk_change[0] & sel0;
	wire force_dc1 = disk_change[1] & sel1;
	wire force_wp  = write_prot[0] & sel0;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			disk_change <= FSR_RST_DISK_CHANGE;
			write_prot  <= FSR_RST_WRITE_PROT;
			ring_filter <= FSR_RST_RING_FILTER;
			irq_mask    <= 3'h0;
			irq_status  <= 3'h0;
		end else begin
			disk_change <= next_disk_change;
			irq_status  <= next_irq_status;
			if (wr & hit_wp)
				write_prot <= pwdata[7:0] & FSR_MASK_WRITE_PROT;
			if (wr & hit_rf)
				ring_filter <= pwdata[7:0] & FSR_MASK_RING_FILTER;
			if (wr & hit_mk)
				irq_mask <= pwdata[2:0];
		end
	end

	// Shadows capture host writes of the write-only originals
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rate_shadow <= FSR_RST_SHADOW;
			ser1_shadow <= FSR_RST_SHADOW;
			ser2_shadow <= FSR_RST_SHADOW;
		end else begin
			if (rate_wr)
				rate_shadow <= host_wdata;
			if (ser1_queue_wr)
				ser1_shadow <= host_wdata;
			if (ser2_queue_wr)
				ser2_shadow <= host_wdata;
		end
	end

	// Zero wait state: pready high in every access phase
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & bad;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	fsr_ring_det #(.TRAIN_CYC(TRAIN_CYC), .GAP_CYC(GAP_CYC)) u_wake (
		.mclk(mclk), .sys_rst(sys_rst), .pin_n(wake_ring_in_n),
		.filter_en(ring_filter[0]), .ring_pulse_n(ring_pn[0]), .ring_event(ring_ev[0]));
	fsr_ring_det #(.TRAIN_CYC(TRAIN_CYC), .GAP_CYC(GAP_CYC)) u_porta (
		.mclk(mclk), .sys_rst(sys_rst), .pin_n(ring_ind_port_a_n),
		.filter_en(ring_filter[1]), .ring_pulse_n(ring_pn[1]), .ring_event(ring_ev[1]));
	fsr_ring_det #(.TRAIN_CYC(TRAIN_CYC), .GAP_CYC(GAP_CYC)) u_portb (
		.mclk(mclk), .sys_rst(sys_rst), .pin_n(ring_ind_port_b_n),
		.filter_en(ring_filter[2]), .ring_pulse_n(ring_pn[2]), .ring_event(ring_ev[2]));

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			disk_changed_status     <= 1'b0;
			disk_change_seen_n      <= 1'b1;
			write_protect_seen_n    <= 1'b1;
			pp_write_protect_seen_n <= 1'b1;
			wake_ring_out_n         <= 1'b1;
			ring_port_a_out_n       <= 1'b1;
			ring_port_b_out_n       <= 1'b1;
			crystal_load_sel        <= 1'b0;
			kbc_port_line_sel       <= 1'b0;
			irq                     <= 1'b0;
		end else begin
			disk_changed_status     <= force_dc0 | force_dc1 | ~dchg_n;
			disk_change_seen_n      <= dchg_n & ~force_dc0 & ~force_dc1;
			write_protect_seen_n    <= wp_n & ~force_wp;
			pp_write_protect_seen_n <= pp_wp_n & ~force_wp;
			wake_ring_out_n         <= ring_pn[0];
			ring_port_a_out_n       <= ring_pn[1];
			ring_port_b_out_n       <= ring_pn[2];
			crystal_load_sel        <= ring_filter[FSR_BIT_CRYSTAL_LOAD_SEL];
			kbc_port_line_sel       <= ring_filter[FSR_BIT_KBC_LINE];
			irq                     <= |(next_irq_status & irq_mask);
		end
	end

	// Force bit of a selected drive always shows on the seen input one cycle later
	property p_force_dc;
		@(posedge mclk) disable iff (sys_rst)
		(disk_change[0] & sel0) |=> !disk_change_seen_n;
	endproperty
	a_force_dc: assert property (p_force_dc) else $error("forced disk change not seen");

	property p_force_dc1;
		@(posedge mclk) disable iff (sys_rst)
		(disk_change[1] & sel1) |=> disk_changed_status;
	endproperty
	a_force_dc1: assert property (p_force_dc1) else $error("drive one change missing");

	property p_unsel;
		@(posedge mclk) disable iff (sys_rst)
		(!sel0 & !sel1 & dchg_n & wp_n) |=> (disk_change_seen_n & write_protect_seen_n);
	endproperty
	a_unsel: assert property (p_unsel) else $error("forcing without selection");

	property p_dc_res;
		@(posedge mclk) disable iff (sys_rst)
		disk_change[7:2] == 6'h00;
	endproperty
	a_dc_res: assert property (p_dc_res) else $error("reserved disk change bits set");

	property p_shadow;
		@(posedge mclk) disable iff (sys_rst)
		rate_wr |=> (rate_shadow == $past(host_wdata));
	endproperty
	a_shadow: assert property (p_shadow) else $error("rate shadow not updated");

	property p_wp;
		@(posedge mclk) disable iff (sys_rst)
		(write_prot[0] & sel0) |=> (!write_protect_seen_n & !pp_write_protect_seen_n);
	endproperty
	a_wp: assert property (p_wp) else $error("forced write protect missing");

	property p_step_clr;
		@(posedge mclk) disable iff (sys_rst)
		(step & sel0 & !(wr & hit_dc & pwdata[0])) |=> !disk_change[0];
	endproperty
	a_step_clr: assert property (p_step_clr) else $error("step did not clear force bit");

	property p_xtal;
		@(posedge mclk) disable iff (sys_rst)
		(wr & hit_rf) ##1 1'b1 |=> (crystal_load_sel == $past(pwdata[6], 2));
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal select mismatch");

	property p_force_dc1_seen;
		@(posedge mclk) disable iff (sys_rst)
		(disk_change[1] & sel1) |=> !disk_change_seen_n;
	endproperty
	a_force_dc1_seen: assert property (p_force_dc1_seen) else $error("drive one change not seen");

	property p_shadow_s1;
		@(posedge mclk) disable iff (sys_rst)
		ser1_queue_wr |=> (ser1_shadow == $past(host_wdata));
	endproperty
	a_shadow_s1: assert property (p_shadow_s1) else $error("first queue shadow not updated");

	property p_shadow_s2;
		@(posedge mclk) disable iff (sys_rst)
		ser2_queue_wr |=> (ser2_shadow == $past(host_wdata));
	endproperty
	a_shadow_s2: assert property (p_shadow_s2) else $error("second queue shadow not updated");

	// Shadows move only on the host strobe, never on bus traffic
	property p_shadow_hold;
		@(posedge mclk) disable iff (sys_rst)
		!rate_wr |=> $stable(rate_shadow);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("rate shadow changed without write");

	property p_queue_hold;
		@(posedge mclk) disable iff (sys_rst)
		(!ser1_queue_wr & !ser2_queue_wr) |=> $stable({ser1_shadow, ser2_shadow});
	endproperty
	a_queue_hold: assert property (p_queue_hold) else $error("queue shadow changed without write");

	property p_shadow_ro;
		@(posedge mclk) disable iff (sys_rst)
		(psel & !penable & pwrite & ro_hit) |=> pslverr;
	endproperty
	a_shadow_ro: assert property (p_shadow_ro) else $error("shadow write not refused");

	property p_unmapped;
		@(posedge mclk) disable iff (sys_rst)
		(psel & !penable & !pwrite & !mapped) |=> (pslverr && (prdata == 32'h0));
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

	property p_pready;
		@(posedge mclk) disable iff (sys_rst)
		(psel & !penable) |=> pready;
	endproperty
	a_pready: assert property (p_pready) else $error("ready missing in access phase");

	property p_pready_low;
		@(posedge mclk) disable iff (sys_rst)
		(psel & penable) |=> !pready;
	endproperty
	a_pready_low: assert property (p_pready_low) else $error("ready held past transfer");

	property p_wp_unsel;
		@(posedge mclk) disable iff (sys_rst)
		(!sel0 & wp_n & pp_wp_n) |=> (write_protect_seen_n & pp_write_protect_seen_n);
	endproperty
	a_wp_unsel: assert property (p_wp_unsel) else $error("write protect forced while unselected");

	property p_wp_res;
		@(posedge mclk) disable iff (sys_rst)
		write_prot[7:1] == 7'h00;
	endproperty
	a_wp_res: assert property (p_wp_res) else $error("reserved write protect bits set");

	property p_dc1_step;
		@(posedge mclk) disable iff (sys_rst)
		(step & sel1 & !(wr & hit_dc & pwdata[1])) |=> !disk_change[1];
	endproperty
	a_dc1_step: assert property (p_dc1_step) else $error("step did not clear drive one bit");

	property p_sw_noclr;
		@(posedge mclk) disable iff (sys_rst)
		(wr & hit_dc & !step) |=> ((disk_change[1:0] & $past(disk_change[1:0])) == $past(disk_change[1:0]));
	endproperty
	a_sw_noclr: assert property (p_sw_noclr) else $error("software cleared a force bit");

	property p_stat_pin;
		@(posedge mclk) disable iff (sys_rst)
		!dchg_n |=> disk_changed_status;
	endproperty
	a_stat_pin: assert property (p_stat_pin) else $error("pin change missing from status");

	property p_stat_idle;
		@(posedge mclk) disable iff (sys_rst)
		(dchg_n & !force_dc0 & !force_dc1) |=> !disk_changed_status;
	endproperty
	a_stat_idle: assert property (p_stat_idle) else $error("status set with no change");

	property p_kbc;
		@(posedge mclk) disable iff (sys_rst)
		(wr & hit_rf) ##1 1'b1 |=> (kbc_port_line_sel == $past(pwdata[7], 2));
	endproperty
	a_kbc: assert property (p_kbc) else $error("port line select mismatch");

	// Set wins over a clear in the same cycle, so no ring is lost
	property p_ring_evt;
		@(posedge mclk) disable iff (sys_rst)
		(|ring_ev) |=> ((irq_status & $past(ring_ev)) == $past(ring_ev));
	endproperty
	a_ring_evt: assert property (p_ring_evt) else $error("ring event not latched");

	// Two cycles of latency: the train flag drains before the output flop
	property p_wake_plain;
		@(posedge mclk) disable iff (sys_rst)
		(!ring_filter[0] ##1 !ring_filter[0]) |-> ##2 wake_ring_out_n;
	endproperty
	a_wake_plain: assert property (p_wake_plain) else $error("wake pulse with filter off");

	property p_porta_plain;
		@(posedge mclk) disable iff (sys_rst)
		(!ring_filter[1] ##1 !ring_filter[1]) |-> ##2 ring_port_a_out_n;
	endproperty
	a_porta_plain: assert property (p_porta_plain) else $error("port A pulse with filter off");

	property p_portb_plain;
		@(posedge mclk) disable iff (sys_rst)
		(!ring_filter[2] ##1 !ring_filter[2]) |-> ##2 ring_port_b_out_n;
	endproperty
	a_portb_plain: assert property (p_portb_plain) else $error("port B pulse with filter off");
endmodule : fsr_cfg
`default_nettype wire

// ==== fsr_cfg_tb.sv ====
// Testbench for the shadow, forced-input and ring filter configuration block
`timescale 1ns/1ns
`default_nettype none
module fsr_cfg_tb
	import fsr_pkg::*;
;
	localparam int TRAIN = 200;
	localparam int GAP   = 60;
	logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        rate_wr, ser1_queue_wr, ser2_queue_wr;
	logic [7:0]  host_wdata;
	logic        disk_change_in_n, write_protect_in_n, pp_write_protect_in_n, head_step_n;
	logic        drive_select_zero_n, drive_select_one_n, wake_ring_in_n, ring_ind_port_a_n, ring_ind_port_b_n;
	logic        disk_changed_status, disk_change_seen_n, write_protect_seen_n, pp_write_protect_seen_n;
	logic        wake_ring_out_n, ring_port_a_out_n, ring_port_b_out_n, crystal_load_sel, kbc_port_line_sel, irq;
	int          n_fail, checks_done, cycles;
	logic [31:0] r;
	logic        er;

	fsr_cfg #(.TRAIN_CYC(TRAIN), .GAP_CYC(GAP)) u_dut (
		.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.rate_wr, .ser1_queue_wr, .ser2_queue_wr, .host_wdata, .disk_change_in_n, .write_protect_in_n,
		.pp_write_protect_in_n, .head_step_n, .drive_select_zero_n, .drive_select_one_n, .wake_ring_in_n,
		.ring_ind_port_a_n, .ring_ind_port_b_n, .disk_changed_status, .disk_change_seen_n,
		.write_protect_seen_n, .pp_write_protect_seen_n, .wake_ring_out_n, .ring_port_a_out_n,
		.ring_port_b_out_n, .crystal_load_sel, .kbc_port_line_sel, .irq
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// Hang guard: whole sequence needs a few hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	// One APB transfer; values read right after the edge are the ones sampled at it
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			n++;
			@(posedge mclk);
		end
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Zero wait state: ready answers the first access phase
		chk("wait states", 32'h0, n);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask : wr

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, r);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask : rd

	task automatic strobe(input int k, input logic [7:0] v);
		@(posedge mclk);
		host_wdata <= v;
		rate_wr <= (k == 0);
		ser1_queue_wr <= (k == 1);
		ser2_queue_wr <= (k == 2);
		@(posedge mclk);
		rate_wr <= 1'b0;
		ser1_queue_wr <= 1'b0;
		ser2_queue_wr <= 1'b0;
	endtask : strobe

	task automatic pin_pulse(input int k);
		@(posedge mclk);
		if (k == 0) wake_ring_in_n <= 1'b0;
		else ring_ind_port_b_n <= 1'b0;
		tick(5);
		wake_ring_in_n <= 1'b1;
		ring_ind_port_b_n <= 1'b1;
	endtask : pin_pulse

	initial begin
		{sys_rst, disk_change_in_n, write_protect_in_n, pp_write_protect_in_n, head_step_n} = 5'h1F;
		{drive_select_zero_n, drive_select_one_n, wake_ring_in_n, ring_ind_port_a_n, ring_ind_port_b_n} = 5'h1F;
		{psel, penable, pwrite, rate_wr, ser1_queue_wr, ser2_queue_wr} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		host_wdata = 8'h00;
		tick(20);
		sys_rst <= 1'b0;
		rd("disk_change", FSR_OFF_DISK_CHANGE, 32'h03);
		rd("write_prot", FSR_OFF_WRITE_PROT, 32'h00);
		rd("ring_filter", FSR_OFF_RING_FILTER, 32'h00);
		chk("crystal_load_sel", 32'h0, {31'h0, crystal_load_sel});
		chk("kbc_port_line_sel", 32'h0, {31'h0, kbc_port_line_sel});
		wr(FSR_OFF_WRITE_PROT, 32'hFF);
		rd("write_prot", FSR_OFF_WRITE_PROT, 32'h01);
		wr(FSR_OFF_DISK_CHANGE, 32'hFC);
		rd("disk_change", FSR_OFF_DISK_CHANGE, 32'h03);
		wr(FSR_OFF_RING_FILTER, 32'hC0);
		tick(2);
		chk("crystal_load_sel", 32'h1, {31'h0, crystal_load_sel});
		chk("kbc_port_line_sel", 32'h1, {31'h0, kbc_port_line_sel});
		wr(FSR_OFF_RING_FILTER, 32'h3F);
		rd("ring_filter", FSR_OFF_RING_FILTER, 32'h07);
		chk("crystal_load_sel", 32'h0, {31'h0, crystal_load_sel});
		chk("kbc_port_line_sel", 32'h0, {31'h0, kbc_port_line_sel});
		// Distinct values per shadow catch crossed strobes
		strobe(0, 8'hDF);
		strobe(1, 8'hCF);
		strobe(2, 8'h4A);
		apb(1'b1, FSR_OFF_RATE_SHADOW, 32'h00);
		chk("shadow write refused", 32'h1, {31'h0, er});
		rd("rate_shadow", FSR_OFF_RATE_SHADOW, 32'hDF);
		rd("ser1_shadow", FSR_OFF_SER1_SHADOW, 32'hCF);
		rd("ser2_shadow", FSR_OFF_SER2_SHADOW, 32'h4A);
		apb(1'b0, 12'h0F0, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, r);
		// Forced disk change, per selected drive, cleared by step
		tick(5);
		chk("disk_changed_status idle", 32'h0, {31'h0, disk_changed_status});
		drive_select_zero_n <= 1'b0;
		tick(5);
		chk("disk_changed_status drv0", 32'h1, {31'h0, disk_changed_status});
		chk("dsk_seen drv0", 32'h0, {31'h0, disk_change_seen_n});
		head_step_n <= 1'b0;
		tick(5);
		head_step_n <= 1'b1;
		rd("disk_change", FSR_OFF_DISK_CHANGE, 32'h02);
		chk("disk_changed_status cleared", 32'h0, {31'h0, disk_changed_status});
		drive_select_zero_n <= 1'b1;
		drive_select_one_n <= 1'b0;
		tick(5);
		chk("disk_changed_status drv1", 32'h1, {31'h0, disk_changed_status});
		wr(FSR_OFF_DISK_CHANGE, 32'h00);
		rd("disk_change", FSR_OFF_DISK_CHANGE, 32'h02);
		head_step_n <= 1'b0;
		tick(5);
		head_step_n <= 1'b1;
		rd("disk_change", FSR_OFF_DISK_CHANGE, 32'h00);
		disk_change_in_n <= 1'b0;
		tick(5);
		chk("disk_changed_status pin", 32'h1, {31'h0, disk_changed_status});
		disk_change_in_n <= 1'b1;
		drive_select_one_n <= 1'b1;
		tick(5);
		chk("wp idle", 32'h1, {31'h0, write_protect_seen_n});
		drive_select_zero_n <= 1'b0;
		tick(5);
		chk("wp forced", 32'h0, {31'h0, write_protect_seen_n});
		chk("pp wp forced", 32'h0, {31'h0, pp_write_protect_seen_n});
		drive_select_zero_n <= 1'b1;
		// Plain edges on wake pin and port B with their filters off; interrupt masked, unmasked, cleared
		wr(FSR_OFF_RING_FILTER, 32'h02);
		wr(FSR_OFF_IRQ_MASK, 32'h0);
		pin_pulse(0);
		pin_pulse(1);
		tick(5);
		chk("wake out idle", 32'h1, {31'h0, wake_ring_out_n});
		rd("irq_status", FSR_OFF_IRQ_STATUS, 32'h5);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(FSR_OFF_IRQ_MASK, 32'h1);
		tick(2);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(FSR_OFF_IRQ_STATUS, 32'h1);
		rd("irq_status", FSR_OFF_IRQ_STATUS, 32'h4);
		tick(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(FSR_OFF_IRQ_STATUS, 32'h4);
		wr(FSR_OFF_RING_FILTER, 32'h03);
		// Filtered trains on wake pin and port A: period well inside the gap limit
		for (int i = 0; i < 12; i++) begin
			{wake_ring_in_n, ring_ind_port_a_n} <= 2'b00;
			tick(5);
			{wake_ring_in_n, ring_ind_port_a_n} <= 2'b11;
			tick(5);
			if (i == 6) chk("ring a train", 32'h0, {31'h0, ring_port_a_out_n});
			if (i == 6) chk("wake train", 32'h0, {31'h0, wake_ring_out_n});
		end
		chk("ring b idle", 32'h1, {31'h0, ring_port_b_out_n});
		tick(GAP + 20);
		chk("ring a ended", 32'h1, {31'h0, ring_port_a_out_n});
		chk("wake ended", 32'h1, {31'h0, wake_ring_out_n});
		rd("irq_status", FSR_OFF_IRQ_STATUS, 32'h3);
		chk("irq wake", 32'h1, {31'h0, irq});
		wr(FSR_OFF_IRQ_STATUS, 32'h3);
		rd("irq_status", FSR_OFF_IRQ_STATUS, 32'h0);
		print_verdict();
	end
endmodule : fsr_cfg_tb
`default_nettype wire
